/* File: src/sdra_map.vh */
// Register offsets, reset values and timing counts of the register bank.
// Assumes it is included once per file by its bare name.
//
// How it works
// - Wide values are big endian, MSB first
// - Upper byte held until LSB is written
// - Freeze stops internal status updates
// - Identification write lasts until next reset
// - Stored configuration replaces defaults at power-up
// - Both monitor failure masks reset to 0x66
// - Soak times reset to 0xAA and 0x55
// - Input zero base frequency resets 0x9C40
// - Both interrupt masks reset to zero
// - Input buffer type resets to 0x10
// - Writing 0x01 to 0x7F toggles page
`ifndef SDRA_MAP_VH
`define SDRA_MAP_VH

`define SDRA_OFF_CHIP_ID 7'h00
`define SDRA_OFF_IN_FAIL_ST 7'h02
`define SDRA_OFF_LOOP_ST 7'h03
`define SDRA_OFF_IN_FAIL_MASK 7'h04
`define SDRA_OFF_LOOP_MASK 7'h05
`define SDRA_OFF_MON_UP_ST 7'h06
`define SDRA_OFF_MON_LO_ST 7'h07
`define SDRA_OFF_MON_UP_MASK 7'h08
`define SDRA_OFF_MON_LO_MASK 7'h09
`define SDRA_OFF_BUF_TYPE 7'h0A
`define SDRA_OFF_SOAK_DISQ 7'h0B
`define SDRA_OFF_SOAK_QUAL 7'h0C
`define SDRA_OFF_FREEZE 7'h0D
`define SDRA_OFF_FREQ_MSB 7'h10
`define SDRA_OFF_FREQ_LSB 7'h11
`define SDRA_OFF_PAGE 7'h7F

`define SDRA_RST_STATUS 8'h00
`define SDRA_RST_IRQ_MASK 8'h00
`define SDRA_RST_MON_MASK 8'h66
`define SDRA_RST_BUF_TYPE 8'h10
`define SDRA_RST_SOAK_DISQ 8'hAA
`define SDRA_RST_SOAK_QUAL 8'h55
`define SDRA_RST_FREEZE 8'h00
`define SDRA_RST_FREQ 16'h9C40
// Upper byte of the frequency default, seeds the hidden hold byte
`define SDRA_RST_FREQ_HOLD 8'h9C
`define SDRA_FREEZE_ON 8'h01
`define SDRA_PAGE_TOGGLE 8'h01

// Host-side settling wait, in ms, and its cycle count at 250 MHz
`define SDRA_CLK_MHZ 250
`define SDRA_HOST_WAIT_MS 10
`define SDRA_HOST_WAIT_CYC (`SDRA_HOST_WAIT_MS * 1000 * `SDRA_CLK_MHZ)

`endif

/* File: src/sdra_regbank.v */
// Register bank behind the serial host port of the clock device.
// Assumes a serial engine on clk delivering one-cycle byte accesses and
// internal monitors on clk raising one-cycle event vectors.
`timescale 1ns/100ps
`default_nettype none
`include "sdra_map.vh"

module sdra_regbank #(
    // Arbitrary neutral identification value
    parameter [7:0] CHIP_ID = 8'hA5
) (
    input wire clk,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [6:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    output reg reg_rvalid_ff,
    input wire otp_we,
    input wire [6:0] otp_addr,
    input wire [7:0] otp_data,
    input wire [7:0] ev_input_fail,
    input wire [7:0] ev_loop,
    input wire [7:0] ev_mon_upper,
    input wire [7:0] ev_mon_lower,
    output reg page_ff,
    output reg [7:0] freeze_ff,
    output reg [7:0] chip_id_ff,
    output reg [7:0] in_fail_st_ff,
    output reg [7:0] loop_st_ff,
    output reg [7:0] mon_up_st_ff,
    output reg [7:0] mon_lo_st_ff,
    output reg [7:0] in_fail_mask_ff,
    output reg [7:0] loop_mask_ff,
    output reg [7:0] mon_up_mask_ff,
    output reg [7:0] mon_lo_mask_ff,
    output reg [7:0] buf_type_ff,
    output reg [7:0] soak_disq_ff,
    output reg [7:0] soak_qual_ff,
    output reg [15:0] base_freq_ff
);

    reg [7:0] freq_hold_ff;
    wire host_wr;
    wire wr_any;
    wire [6:0] wa;
    wire [7:0] wd;
    wire frozen;
    reg [7:0] nxt_rdata;
    // One strobe per register so no register block has to decode the address itself
    wire page_we;
    wire id_we;
    wire freeze_we;
    wire in_fail_st_we;
    wire loop_st_we;
    wire mon_up_st_we;
    wire mon_lo_st_we;
    wire in_fail_mask_we;
    wire loop_mask_we;
    wire mon_up_mask_we;
    wire mon_lo_mask_we;
    wire buf_type_we;
    wire soak_disq_we;
    wire soak_qual_we;
    wire freq_msb_we;
    wire freq_lsb_we;

    function hit;
        input [6:0] a;
        input [6:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Status update on one latched register: set while unfrozen, host write while frozen
    function [7:0] sticky;
        input [7:0] cur;
        input [7:0] ev;
        input lock;
        input wr;
        input [7:0] d;
        begin
            if (!lock) begin
                sticky = cur | ev;
            end else if (wr) begin
                sticky = d;
            end else begin
                sticky = cur;
            end
        end
    endfunction

    // Upper page holds nothing here but the page register, so other host writes there are dropped
    assign host_wr = reg_wr & ~page_ff;
    // Stored configuration loads take the port ahead of the host
    assign wr_any = otp_we | host_wr;
    assign wa = otp_we ? otp_addr : reg_addr;
    assign wd = otp_we ? otp_data : reg_wdata;
    assign frozen = (freeze_ff != `SDRA_RST_FREEZE);

    assign page_we = reg_wr && hit(reg_addr, `SDRA_OFF_PAGE) &&
        (reg_wdata == `SDRA_PAGE_TOGGLE);
    assign id_we = host_wr && hit(reg_addr, `SDRA_OFF_CHIP_ID);
    assign freeze_we = host_wr && hit(reg_addr, `SDRA_OFF_FREEZE);
    assign in_fail_st_we = host_wr && hit(reg_addr, `SDRA_OFF_IN_FAIL_ST);
    assign loop_st_we = host_wr && hit(reg_addr, `SDRA_OFF_LOOP_ST);
    assign mon_up_st_we = host_wr && hit(reg_addr, `SDRA_OFF_MON_UP_ST);
    assign mon_lo_st_we = host_wr && hit(reg_addr, `SDRA_OFF_MON_LO_ST);
    assign in_fail_mask_we = wr_any && hit(wa, `SDRA_OFF_IN_FAIL_MASK);
    assign loop_mask_we = wr_any && hit(wa, `SDRA_OFF_LOOP_MASK);
    assign mon_up_mask_we = wr_any && hit(wa, `SDRA_OFF_MON_UP_MASK);
    assign mon_lo_mask_we = wr_any && hit(wa, `SDRA_OFF_MON_LO_MASK);
    assign buf_type_we = wr_any && hit(wa, `SDRA_OFF_BUF_TYPE);
    assign soak_disq_we = wr_any && hit(wa, `SDRA_OFF_SOAK_DISQ);
    assign soak_qual_we = wr_any && hit(wa, `SDRA_OFF_SOAK_QUAL);
    assign freq_msb_we = wr_any && hit(wa, `SDRA_OFF_FREQ_MSB);
    assign freq_lsb_we = wr_any && hit(wa, `SDRA_OFF_FREQ_LSB);

    // Page register is reachable from both pages
    // page toggle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            page_ff <= 1'b0;
        end else if (page_we) begin
            page_ff <= ~page_ff;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chip_id_ff <= CHIP_ID;
        end else if (id_we) begin
            chip_id_ff <= reg_wdata;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            freeze_ff <= `SDRA_RST_FREEZE;
        end else if (freeze_we) begin
            freeze_ff <= reg_wdata;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_fail_st_ff <= `SDRA_RST_STATUS;
        end else begin
            in_fail_st_ff <= sticky(in_fail_st_ff, ev_input_fail, frozen,
                in_fail_st_we, reg_wdata);
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loop_st_ff <= `SDRA_RST_STATUS;
        end else begin
            loop_st_ff <= sticky(loop_st_ff, ev_loop, frozen,
                loop_st_we, reg_wdata);
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mon_up_st_ff <= `SDRA_RST_STATUS;
        end else begin
            mon_up_st_ff <= sticky(mon_up_st_ff, ev_mon_upper, frozen,
                mon_up_st_we, reg_wdata);
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mon_lo_st_ff <= `SDRA_RST_STATUS;
        end else begin
            mon_lo_st_ff <= sticky(mon_lo_st_ff, ev_mon_lower, frozen,
                mon_lo_st_we, reg_wdata);
        end
    end

    // Configuration registers; stored values arrive over the load port after reset
    // stored configuration load
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_fail_mask_ff <= `SDRA_RST_IRQ_MASK;
        end else if (in_fail_mask_we) begin
            in_fail_mask_ff <= wd;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loop_mask_ff <= `SDRA_RST_IRQ_MASK;
        end else if (loop_mask_we) begin
            loop_mask_ff <= wd;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mon_up_mask_ff <= `SDRA_RST_MON_MASK;
        end else if (mon_up_mask_we) begin
            mon_up_mask_ff <= wd;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mon_lo_mask_ff <= `SDRA_RST_MON_MASK;
        end else if (mon_lo_mask_we) begin
            mon_lo_mask_ff <= wd;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_type_ff <= `SDRA_RST_BUF_TYPE;
        end else if (buf_type_we) begin
            buf_type_ff <= wd;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            soak_disq_ff <= `SDRA_RST_SOAK_DISQ;
        end else if (soak_disq_we) begin
            soak_disq_ff <= wd;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            soak_qual_ff <= `SDRA_RST_SOAK_QUAL;
        end else if (soak_qual_we) begin
            soak_qual_ff <= wd;
        end
    end

    // The held byte is invisible; reads show the applied value so a half
    // written frequency never reaches the loop logic
    // big endian pairing
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            freq_hold_ff <= `SDRA_RST_FREQ_HOLD;
        end else if (freq_msb_we) begin
            freq_hold_ff <= wd;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            base_freq_ff <= `SDRA_RST_FREQ;
        end else if (freq_lsb_we) begin
            base_freq_ff <= {freq_hold_ff, wd};
        end
    end

    always @* begin
        nxt_rdata = 8'h00;
        if (hit(reg_addr, `SDRA_OFF_PAGE)) begin
            nxt_rdata = {7'h00, page_ff};
        end else if (!page_ff) begin
            case (reg_addr)
                `SDRA_OFF_CHIP_ID: nxt_rdata = chip_id_ff;
                `SDRA_OFF_IN_FAIL_ST: nxt_rdata = in_fail_st_ff;
                `SDRA_OFF_LOOP_ST: nxt_rdata = loop_st_ff;
                `SDRA_OFF_IN_FAIL_MASK: nxt_rdata = in_fail_mask_ff;
                `SDRA_OFF_LOOP_MASK: nxt_rdata = loop_mask_ff;
                `SDRA_OFF_MON_UP_ST: nxt_rdata = mon_up_st_ff;
                `SDRA_OFF_MON_LO_ST: nxt_rdata = mon_lo_st_ff;
                `SDRA_OFF_MON_UP_MASK: nxt_rdata = mon_up_mask_ff;
                `SDRA_OFF_MON_LO_MASK: nxt_rdata = mon_lo_mask_ff;
                `SDRA_OFF_BUF_TYPE: nxt_rdata = buf_type_ff;
                `SDRA_OFF_SOAK_DISQ: nxt_rdata = soak_disq_ff;
                `SDRA_OFF_SOAK_QUAL: nxt_rdata = soak_qual_ff;
                `SDRA_OFF_FREEZE: nxt_rdata = freeze_ff;
                `SDRA_OFF_FREQ_MSB: nxt_rdata = base_freq_ff[15:8];
                `SDRA_OFF_FREQ_LSB: nxt_rdata = base_freq_ff[7:0];
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff <= 8'h00;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

endmodule // sdra_regbank

`default_nettype wire

/* File: tb/sdra_host.sv */
// Host model for the byte access bus of the register bank.
// Assumes the bank samples on rising clk and answers reads a cycle later.
`timescale 1ns/100ps
`default_nettype none
module sdra_host #(
    parameter int WAIT_CYC = 40
) (
    input wire logic clk,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic reg_rvalid_ff,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse so stale values never pass
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        d = reg_rvalid_ff ? reg_rdata_ff : 8'hXX;
        {reg_rd, reg_addr} = {1'b0, ~a};
    endtask
    task automatic lock();
        wr(7'h0D, 8'h01);
    endtask
    task automatic unlock();
        wr(7'h0D, 8'h00);
    endtask
    task automatic settle();
        repeat (WAIT_CYC) @(negedge clk);
    endtask
endmodule // sdra_host
`default_nettype wire

/* File: tb/sdra_regbank_asserts.sv */
// Concurrent checks on the register bank ports.
// Assumes a bind onto sdra_regbank sharing its clock and reset.
`timescale 1ns/100ps
`default_nettype none
module sdra_regbank_asserts (
    input wire clk,
    input wire nrst,
    input wire reg_wr,
    input wire [6:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire otp_we,
    input wire [6:0] otp_addr,
    input wire [7:0] ev_input_fail,
    input wire page_ff,
    input wire [7:0] freeze_ff,
    input wire [7:0] chip_id_ff,
    input wire [7:0] in_fail_st_ff,
    input wire [7:0] loop_st_ff,
    input wire [7:0] loop_mask_ff,
    input wire [7:0] mon_up_mask_ff,
    input wire [7:0] buf_type_ff,
    input wire [7:0] soak_qual_ff,
    input wire [15:0] base_freq_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire host = reg_wr && !page_ff && !otp_we;
    sequence msb_wr; host && reg_addr == 7'h10; endsequence
    sequence lsb_wr; host && reg_addr == 7'h11; endsequence
    sequence gap_cyc; !reg_wr && !otp_we; endsequence
    freq_pair_a: assert property (msb_wr ##1 gap_cyc ##1 lsb_wr |=>
        base_freq_ff == {$past(reg_wdata, 3), $past(reg_wdata)}) else $error("pair not applied");
    freq_hold_a: assert property (!(reg_wr && reg_addr == 7'h11) &&
        !(otp_we && otp_addr == 7'h11) |=> $stable(base_freq_ff)) else $error("freq moved");
    frozen_hold_a: assert property (freeze_ff != 8'h00 && !reg_wr |=>
        $stable(loop_st_ff)) else $error("frozen status moved");
    sticky_set_a: assert property (freeze_ff == 8'h00 |=>
        in_fail_st_ff == ($past(in_fail_st_ff) | $past(ev_input_fail))) else $error("sticky");
    frozen_clear_a: assert property (freeze_ff != 8'h00 && host && reg_addr == 7'h02 |=>
        in_fail_st_ff == $past(reg_wdata)) else $error("clear lost");
    id_write_a: assert property (host && reg_addr == 7'h00 |=>
        chip_id_ff == $past(reg_wdata)) else $error("id write lost");
    page_flip_a: assert property (1'b1 |=> page_ff ==
        ($past(page_ff) ^ $past(reg_wr && reg_addr == 7'h7F && reg_wdata == 8'h01)))
        else $error("page wrong");
    reset_vals_a: assert property ($rose(nrst) |->
        mon_up_mask_ff == 8'h66 && soak_qual_ff == 8'h55 && buf_type_ff == 8'h10 &&
        loop_mask_ff == 8'h00 && base_freq_ff == 16'h9C40) else $error("reset value wrong");
endmodule // sdra_regbank_asserts
bind sdra_regbank sdra_regbank_asserts u_chk (.clk, .nrst, .reg_wr, .reg_addr, .reg_wdata,
    .otp_we, .otp_addr, .ev_input_fail, .page_ff, .freeze_ff, .chip_id_ff, .in_fail_st_ff,
    .loop_st_ff, .loop_mask_ff, .mon_up_mask_ff, .buf_type_ff, .soak_qual_ff, .base_freq_ff);
`default_nettype wire

/* File: tb/sdra_regbank_test.sv */
// Self-checking bench for the register bank.
// Assumes the host model owns the byte bus; this bench drives loader and events.
`timescale 1ns/100ps
`default_nettype none
module sdra_regbank_test;
    localparam logic [7:0] ID = 8'h3C; // arbitrary identification value
    logic clk = 1'b0, nrst = 1'b0, reg_wr, reg_rd, reg_rvalid_ff, page_ff, otp_we = 1'b0;
    logic [6:0] reg_addr, otp_addr = 7'h00;
    logic [7:0] reg_wdata, reg_rdata_ff, otp_data = 8'h00, ev_input_fail = 8'h00;
    logic [7:0] ev_loop = 8'h00, ev_mon_upper = 8'h00, ev_mon_lower = 8'h00, d;
    logic [7:0] freeze_ff, chip_id_ff, in_fail_st_ff, loop_st_ff, mon_up_st_ff, mon_lo_st_ff;
    logic [7:0] in_fail_mask_ff, loop_mask_ff, mon_up_mask_ff, mon_lo_mask_ff, buf_type_ff;
    logic [7:0] soak_disq_ff, soak_qual_ff;
    logic [15:0] base_freq_ff;
    int n_fail = 0, total_checks = 0;
    logic [6:0] ra [16] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17, 14};
    logic [7:0] re [16] = '{ID, 0, 0, 0, 0, 0, 0, 8'h66, 8'h66, 8'h10, 8'hAA, 8'h55, 0,
        8'h9C, 8'h40, 0};
    sdra_regbank #(.CHIP_ID(ID)) u_sdra_regbank (.clk, .nrst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata_ff, .reg_rvalid_ff, .otp_we, .otp_addr, .otp_data,
        .ev_input_fail, .ev_loop, .ev_mon_upper, .ev_mon_lower, .page_ff, .freeze_ff,
        .chip_id_ff, .in_fail_st_ff, .loop_st_ff, .mon_up_st_ff, .mon_lo_st_ff,
        .in_fail_mask_ff, .loop_mask_ff, .mon_up_mask_ff, .mon_lo_mask_ff, .buf_type_ff,
        .soak_disq_ff, .soak_qual_ff, .base_freq_ff);
    sdra_host u_sdra_host (.clk, .reg_rdata_ff, .reg_rvalid_ff, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata);
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic ev_pulse(input logic [7:0] v);
        @(negedge clk);
        {ev_input_fail, ev_loop, ev_mon_upper, ev_mon_lower} = {4{v}};
        @(negedge clk);
        {ev_input_fail, ev_loop, ev_mon_upper, ev_mon_lower} = 32'h0;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 16; i++) begin
            u_sdra_host.rd(ra[i], d);
            chk(d, re[i]);
        end
        chk({in_fail_mask_ff, loop_mask_ff}, 16'h0000);
        chk({mon_up_mask_ff, mon_lo_mask_ff}, 16'h6666);
        chk({buf_type_ff, soak_qual_ff}, 16'h1055);
        chk({mon_up_st_ff, freeze_ff}, 16'h0000);
    endtask
    task automatic t_freq();
        u_sdra_host.lock();
        u_sdra_host.wr(7'h10, 8'h12);
        chk(base_freq_ff, 16'h9C40);
        u_sdra_host.wr(7'h11, 8'h34);
        chk(base_freq_ff, 16'h1234);
        u_sdra_host.wr(7'h0A, 8'h03);
        chk(buf_type_ff, 8'h03);
        u_sdra_host.rd(7'h10, d);
        chk(d, 8'h12);
        u_sdra_host.settle();
        u_sdra_host.unlock();
    endtask
    task automatic t_sticky();
        u_sdra_host.wr(7'h02, 8'hFF);
        ev_pulse(8'h81);
        chk(in_fail_st_ff, 8'h81);
        chk(mon_lo_st_ff, 8'h81);
        chk(mon_up_st_ff, 8'h81);
        u_sdra_host.lock();
        chk(freeze_ff, 8'h01);
        ev_pulse(8'h18);
        chk(loop_st_ff, 8'h81);
        u_sdra_host.wr(7'h03, 8'h00);
        chk(loop_st_ff, 8'h00);
        u_sdra_host.unlock();
        ev_pulse(8'h02);
        u_sdra_host.settle();
        u_sdra_host.rd(7'h03, d);
        chk(d, 8'h02);
    endtask
    task automatic t_otp();
        @(negedge clk);
        {otp_we, otp_addr, otp_data} = {1'b1, 7'h0B, 8'h3C};
        @(negedge clk);
        {otp_we, otp_addr, otp_data} = {1'b0, 7'h74, 8'hC3};
        chk(soak_disq_ff, 8'h3C);
    endtask
    task automatic t_page();
        u_sdra_host.wr(7'h7F, 8'h01);
        u_sdra_host.wr(7'h0C, 8'h00);
        chk(soak_qual_ff, 8'h55);
        u_sdra_host.wr(7'h7F, 8'h02);
        u_sdra_host.rd(7'h7F, d);
        chk(d, 8'h01);
        u_sdra_host.wr(7'h7F, 8'h01);
        chk(page_ff, 1'b0);
    endtask
    task automatic t_id();
        u_sdra_host.wr(7'h00, 8'h5A);
        chk(chip_id_ff, 8'h5A);
        @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        chk(chip_id_ff, ID);
        chk(soak_disq_ff, 8'hAA);
        chk(buf_type_ff, 8'h10);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_freq();
        t_sticky();
        t_otp();
        t_page();
        t_id();
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule // sdra_regbank_test
`default_nettype wire
